// file: include/nsmb_pkg.sv
// package: register map, coordination bit positions and mailbox types for the send mailbox block
package nsmb_pkg;
  // register byte offsets on the ahb-lite slave
  localparam logic [7:0] off_ctrl = 8'h00;     // send coordination byte (low byte, high byte when placed in a data word)
  localparam logic [7:0] off_param = 8'h04;    // staged startup parameters
  localparam logic [7:0] off_active = 8'h08;   // parameters in force (read only)
  localparam logic [7:0] off_status = 8'h0c;   // run state and last destination class
  localparam logic [7:0] off_mbox = 8'h40;     // first mailbox word, 33 words in all
  localparam int mbox_words = 33;
  localparam int max_len = 64;
  // send coordination byte fields
  localparam int busy_bit = 7;
  localparam int express_bit = 4;
  localparam int error_bit = 0;
  // station numbers
  localparam logic [4:0] station_default = 5'h01;
  localparam logic [4:0] station_max = 5'h1e;
  localparam logic [4:0] dest_broadcast = 5'h1f;
  // location type identifiers in ascii
  localparam logic [7:0] loc_flag_id = 8'h4d;
  localparam logic [7:0] loc_word_id = 8'h44;
  // wait for network completion in ns, at most this long
  localparam int send_timeout_ns = 100000;
  localparam int clk_ns = 40;
  localparam int send_timeout_cyc = send_timeout_ns / clk_ns;

  typedef enum logic [1:0] {dest_master, dest_slave, dest_broadcast_c, dest_invalid} nsmb_dest_e;

  typedef struct packed {
    logic [4:0] own_station;   // own_station_number
    logic [4:0] pg_station;    // programmer_station_number
    logic coord_in_word;       // coordination byte in word_high_byte
  } nsmb_param_s;

  typedef struct packed {
    logic [7:0] len;
    logic [4:0] dest;
    logic express;
  } nsmb_hdr_s;
endpackage : nsmb_pkg

// file: hw/nsmb_top.sv
// send mailbox handshake block with ahb-lite register access and a byte stream to the network
//
// Decided for this implementation: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - own station number from parameters, 1 to 30, default 1
// - programmer station number 1 to 30, default 1
// - coordination byte in a data word uses the word's high byte
// - parameters take effect only on stop-to-run or power-on
// - word mailbox: length high byte, destination low byte, payload to word 33
// - busy clears once the network reports done or failure, or the wait times out
// - express bit 4 gives priority, may drop a queued telegram
// - express messages are marked express toward the receiver
// - failed send sets error bit 0
// - overlong incoming data is cut at mailbox end, no overflow report
// - location identifiers are ascii 4d flag and 44 data word
module nsmb_top #(
  parameter int timeout_cyc = nsmb_pkg::send_timeout_cyc // network answer wait
) (
  input wire logic hclk,             // bus clock, 25 mhz
  input wire logic hresetn,          // async reset, active low
  input wire logic clk_en,           // freezes all state while low
  input wire logic hsel,             // ahb slave select
  input wire logic [7:0] haddr,      // ahb byte address
  input wire logic [1:0] htrans,     // ahb transfer type
  input wire logic hwrite,           // ahb write
  input wire logic [2:0] hsize,      // ahb size, word only
  input wire logic [31:0] hwdata,    // ahb write data
  input wire logic hready,           // ahb bus ready
  output logic [31:0] hrdata,        // ahb read data
  output logic hreadyout,            // ahb slave ready
  output logic hresp,                // ahb response, always okay
  input wire logic run_mode,         // controller in run
  input wire logic power_on_load,    // battery-backed power-on pulse
  output logic tx_valid,             // network byte valid
  output logic [7:0] tx_byte,        // network byte
  output logic tx_express,           // message is express
  output logic tx_last,              // last byte of message
  input wire logic tx_ready,         // network takes byte
  input wire logic tx_done,          // network reports message delivered
  input wire logic tx_fail,          // network reports failure
  output logic [7:0] loc_id          // ascii location type of coordination byte
);
  // refuse a timeout that the wait counter cannot serve
  if (timeout_cyc < 1) begin : g_bad_timeout
    $error("timeout_cyc must be at least 1");
  end

  typedef enum logic [1:0] {st_idle, st_send, st_wait} nsmb_st_e;

  //////////////////////////////////////////////////////////////////////////////
  // bus address phase capture
  logic wr_pend_q, rd_pend_q;
  logic [7:0] addr_q;
  logic [7:0] coord_q;
  logic [31:0] mbox_q [nsmb_pkg::mbox_words];
  logic [31:0] snap_q [nsmb_pkg::mbox_words];
  nsmb_pkg::nsmb_param_s stage_q, act_q;
  nsmb_pkg::nsmb_hdr_s hdr_q;
  nsmb_st_e st_q;
  logic [6:0] idx_q;
  logic [31:0] tmo_q;
  logic run_q;
  logic [31:0] rdata_d;

  wire logic addr_ok = hsel & hready & htrans[1];
  wire logic is_ctrl = addr_q == nsmb_pkg::off_ctrl;
  wire logic is_param = addr_q == nsmb_pkg::off_param;
  wire logic is_mbox = addr_q >= nsmb_pkg::off_mbox
                    && addr_q < nsmb_pkg::off_mbox + 8'(4 * nsmb_pkg::mbox_words);
  wire logic [5:0] mbox_idx = 6'((addr_q - nsmb_pkg::off_mbox) >> 2);
  wire logic busy = coord_q[nsmb_pkg::busy_bit];
  // coordination byte lane: high byte of the word when placed in a data word
  wire logic [7:0] coord_wr = act_q.coord_in_word ? hwdata[15:8] : hwdata[7:0];
  wire logic [31:0] coord_rd = act_q.coord_in_word ? {16'h0000, coord_q, 8'h00}
                                                   : {24'h000000, coord_q};
  // start is a write that sets bit 7 while idle; writes while busy are ignored
  wire logic start_req = wr_pend_q & is_ctrl & ~busy & coord_wr[nsmb_pkg::busy_bit];
  wire logic load_param = (run_mode & ~run_q) | power_on_load;
  wire logic [7:0] len_clip = hdr_q.len > 8'(nsmb_pkg::max_len)
                              ? 8'(nsmb_pkg::max_len) : hdr_q.len;
  // length as it leaves the mailbox at the start edge, clipped like the header copy
  wire logic [7:0] start_len = mbox_q[0][15:8] > 8'(nsmb_pkg::max_len)
                               ? 8'(nsmb_pkg::max_len) : mbox_q[0][15:8];
  wire nsmb_pkg::nsmb_dest_e dest_cls = hdr_q.dest == 5'h00 ? nsmb_pkg::dest_master
    : hdr_q.dest == nsmb_pkg::dest_broadcast ? nsmb_pkg::dest_broadcast_c
    : nsmb_pkg::dest_slave;
  wire logic last_b = idx_q == 7'(len_clip + 8'd1);
  // stream byte j: 0 length, 1 destination, else word j/2 with the high byte on even j
  // the index stops at the last byte, so the word select stays in the mailbox while sending
  wire logic [6:0] nxt_idx = (tx_ready && !last_b) ? idx_q + 7'd1 : idx_q;
  wire logic [31:0] nxt_w = snap_q[nxt_idx[6:1]];
  wire logic [7:0] nxt_b = nxt_idx == 7'd0 ? len_clip
                         : nxt_idx == 7'd1 ? {3'b000, hdr_q.dest}
                         : nxt_idx[0] ? nxt_w[7:0] : nxt_w[15:8];

  //////////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb begin
    rdata_d = 32'h00000000;
    if (is_ctrl) rdata_d = coord_rd;
    else if (is_param) rdata_d = {21'h000000, stage_q};
    else if (addr_q == nsmb_pkg::off_active) rdata_d = {21'h000000, act_q};
    else if (addr_q == nsmb_pkg::off_status) rdata_d = {28'h0000000, dest_cls, st_q != st_idle, run_q};
    else if (is_mbox) rdata_d = mbox_q[mbox_idx];
  end

  // one wait state on reads: the registered read data is loaded during it
  assign hreadyout = ~rd_pend_q;
  assign hresp = 1'b0;
  assign tx_valid = st_q == st_send;
  assign tx_express = hdr_q.express;
  assign tx_last = tx_valid & last_b;
  assign loc_id = act_q.coord_in_word ? nsmb_pkg::loc_word_id : nsmb_pkg::loc_flag_id;

  //////////////////////////////////////////////////////////////////////////////
  // bus phase tracking and read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 8'h00;
      hrdata <= 32'h00000000;
    end else if (clk_en) begin
      wr_pend_q <= addr_ok & hwrite;
      rd_pend_q <= addr_ok & ~hwrite;
      if (addr_ok) addr_q <= {haddr[7:2], 2'b00};
      if (rd_pend_q) hrdata <= rdata_d;
    end
  end

  // mailbox words, program side; copied to the send snapshot at start, so writes while busy do not change the message
  genvar gi;
  generate
    for (gi = 0; gi < nsmb_pkg::mbox_words; gi++) begin : g_mbox
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          mbox_q[gi] <= 32'h00000000;
          snap_q[gi] <= 32'h00000000;
        end else if (clk_en) begin
          if (wr_pend_q && is_mbox && mbox_idx == 6'(gi)) mbox_q[gi] <= {16'h0000, hwdata[15:0]};
          if (start_req) snap_q[gi] <= mbox_q[gi];
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // parameters: staged by software, applied on stop-to-run or power-on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage_q <= '{nsmb_pkg::station_default, nsmb_pkg::station_default, 1'b0};
      act_q <= '{nsmb_pkg::station_default, nsmb_pkg::station_default, 1'b0};
      run_q <= 1'b0;
    end else if (clk_en) begin
      run_q <= run_mode;
      if (wr_pend_q && is_param) begin
        // out-of-range station numbers fall back to the default
        stage_q.own_station <= (hwdata[10:6] == 5'h00 || hwdata[10:6] > nsmb_pkg::station_max)
                               ? nsmb_pkg::station_default : hwdata[10:6];
        stage_q.pg_station <= (hwdata[5:1] == 5'h00 || hwdata[5:1] > nsmb_pkg::station_max)
                              ? nsmb_pkg::station_default : hwdata[5:1];
        stage_q.coord_in_word <= hwdata[0];
      end
      if (load_param) act_q <= stage_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // send sequencer and coordination byte
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= st_idle;
      coord_q <= 8'h00;
      hdr_q <= '0;
      idx_q <= 7'd0;
      tmo_q <= 32'd0;
      tx_byte <= 8'h00;
    end else if (clk_en) begin
      unique case (st_q)
        st_idle: begin
          if (start_req) begin
            // error cleared at a new start, busy set until done
            coord_q <= {1'b1, 2'b00, coord_wr[nsmb_pkg::express_bit], 4'h0};
            hdr_q <= '{start_len, mbox_q[0][4:0], coord_wr[nsmb_pkg::express_bit]};
            idx_q <= 7'd0;
            tx_byte <= start_len;
            st_q <= st_send;
          end else if (wr_pend_q && is_ctrl) begin
            coord_q <= coord_wr & 8'h10;
          end
        end
        st_send: begin
          if (tx_ready) begin
            idx_q <= idx_q + 7'd1;
            tmo_q <= 32'd0;
            if (last_b) st_q <= st_wait;
          end
          tx_byte <= nxt_b;
        end
        st_wait: begin
          tmo_q <= tmo_q + 32'd1;
          if (tx_done || tx_fail || tmo_q == 32'(timeout_cyc - 1)) begin
            coord_q[nsmb_pkg::busy_bit] <= 1'b0;
            coord_q[nsmb_pkg::error_bit] <= ~tx_done;
            st_q <= st_idle;
          end
        end
        default: st_q <= st_idle;
      endcase
    end
  end
  // express priority: a queued telegram is dropped by the network side on tx_express
  wire logic unused_ok = &{1'b0, hsize, hwdata[31:16]};
endmodule : nsmb_top
`default_nettype wire

// file: tb/nsmb_sva.sv
// checker: port-level timing of the send mailbox block
`timescale 1ns/1ps
`default_nettype none
module nsmb_sva (
  input wire logic hclk, // clock
  input wire logic hresetn, // reset, active low
  input wire logic clk_en, // state enable
  input wire logic hreadyout, // slave ready
  input wire logic hresp, // bus response
  input wire logic tx_valid, // byte offered
  input wire logic [7:0] tx_byte, // byte
  input wire logic tx_express, // express mark
  input wire logic tx_last, // last byte
  input wire logic tx_ready, // byte taken
  input wire logic [7:0] loc_id // location type
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // length byte of a new message taken, and last byte taken
  sequence s_len_taken;
    $rose(tx_valid) ##0 (tx_ready && clk_en);
  endsequence
  sequence s_last_taken;
    tx_valid && tx_ready && tx_last && clk_en;
  endsequence
  chk_bus_okay: assert property (!hresp) else $error("bus response not okay");
  chk_wait_one: assert property (!hreadyout && clk_en |=> hreadyout)
    else $error("read wait longer than one cycle");
  chk_loc_code: assert property (loc_id == 8'h4d || loc_id == 8'h44)
    else $error("location code not ascii");
  chk_last_valid: assert property (tx_last |-> tx_valid) else $error("last without valid");
  chk_byte_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
    else $error("byte dropped while stalled");
  chk_express_hold: assert property (tx_valid && $past(tx_valid) |-> $stable(tx_express))
    else $error("express mark changed in a message");
  chk_len_limit: assert property ($rose(tx_valid) |-> tx_byte <= 8'h40)
    else $error("length byte above 64");
  chk_dest_code: assert property (s_len_taken |=> tx_valid && tx_byte[7:5] == 3'h0)
    else $error("destination above 31");
  chk_end_quiet: assert property (s_last_taken |=> !tx_valid)
    else $error("bytes after last");
endmodule : nsmb_sva
bind nsmb_top nsmb_sva i_nsmb_sva (.hclk, .hresetn, .clk_en, .hreadyout, .hresp,
  .tx_valid, .tx_byte, .tx_express, .tx_last, .tx_ready, .loc_id);
`default_nettype wire

// file: tb/nsmb_net_model.sv
// partner model: network side taking message bytes and reporting delivery
`timescale 1ns/1ps
`default_nettype none
module nsmb_net_model (
  input wire logic hclk, // clock
  input wire logic hresetn, // reset, active low
  input wire logic tx_valid, // byte offered
  input wire logic [7:0] tx_byte, // byte
  input wire logic tx_express, // express mark
  input wire logic tx_last, // last byte
  input wire logic slow, // take a byte every other cycle
  input wire logic [1:0] verdict, // 0 delivered, 1 failed, else silent
  output logic tx_ready, // byte taken
  output logic tx_done, // delivered pulse
  output logic tx_fail // failure pulse
);
  logic [7:0] rx_q [256]; // bytes taken, wrapping
  logic [7:0] rx_n; // count of bytes taken
  logic xp_q; // express mark seen
  logic ph_q; // stall phase
  logic end_q; // last byte taken a cycle ago
  // store accepted bytes, answer one cycle after the last
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_n <= 8'h0;
      xp_q <= 1'h0;
      ph_q <= 1'h0;
      end_q <= 1'h0;
    end else begin
      ph_q <= ~ph_q;
      end_q <= tx_valid && tx_ready && tx_last;
      if (tx_valid && tx_ready) begin
        rx_q[rx_n] <= tx_byte;
        rx_n <= rx_n + 8'h1;
        xp_q <= tx_express;
      end
    end
  end
  assign tx_ready = !slow || ph_q;
  assign tx_done = end_q && verdict == 2'h0;
  assign tx_fail = end_q && verdict == 2'h1;
endmodule : nsmb_net_model
`default_nettype wire

// file: tb/test_nsmb_top.sv
// testbench: mailbox sends, parameter loads and refusals over the bus
`timescale 1ns/1ps
`default_nettype none
module test_nsmb_top;
  typedef struct {int len; int dest; int xp; int slow; int vd; int elen; int err;} nsmb_row_s;
  nsmb_row_s rows [5] = '{'{3, 0, 0, 0, 0, 3, 0}, '{64, 30, 1, 1, 0, 64, 0},
    '{0, 31, 0, 0, 1, 0, 1}, '{5, 1, 0, 0, 2, 5, 1}, '{70, 2, 1, 0, 0, 64, 0}};
  logic hclk = 0, hresetn = 0, run_mode = 0, pol = 0, hwrite = 0, slow = 0, ce = 1;
  logic [7:0] haddr = 8'h0, tx_byte, loc_id;
  logic [1:0] htrans = 2'h0, vd = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic hreadyout, hresp, tx_valid, tx_express, tx_last, tx_ready, tx_done, tx_fail;
  int num_errors = 0, checks = 0, cyc = 0, sh = 0;
  always #20 hclk = ~hclk;
  nsmb_top #(.timeout_cyc(20)) i_nsmb_top (.hclk, .hresetn, .clk_en(ce), .hsel(1'h1),
    .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .run_mode, .power_on_load(pol), .tx_valid, .tx_byte, .tx_express,
    .tx_last, .tx_ready, .tx_done, .tx_fail, .loc_id);
  nsmb_net_model i_nsmb_net_model (.hclk, .hresetn, .tx_valid, .tx_byte, .tx_express,
    .tx_last, .slow, .verdict(vd), .tx_ready, .tx_done, .tx_fail);
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask : chk
  // one single bus transfer; read data is taken at the edge that ends the data phase
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask : xfer
  function automatic logic [7:0] pb(input int i);
    return 8'(i * 5 + 3);
  endfunction : pb
  // fill the mailbox, start, poll busy, then compare what the network saw
  task automatic send(input nsmb_row_s r);
    logic [7:0] b;
    b = i_nsmb_net_model.rx_n;
    vd <= r.vd[1:0];
    slow <= r.slow[0];
    xfer(nsmb_pkg::off_mbox, 1'h1, {16'h0, r.len[7:0], r.dest[7:0]});
    for (int k = 1; k < 33; k++)
      xfer(nsmb_pkg::off_mbox + 8'(4 * k), 1'h1, {16'h0, pb(2 * k - 2), pb(2 * k - 1)});
    xfer(nsmb_pkg::off_ctrl, 1'h1, (32'h80 | 32'(r.xp * 16)) << sh);
    if (r.len > 8 || r.vd == 2) begin
      xfer(nsmb_pkg::off_ctrl, 1'h0, 32'h0);
      chk(1, rd[7 + sh]);
      xfer(nsmb_pkg::off_mbox + 8'h4, 1'h1, 32'hffff);
      xfer(nsmb_pkg::off_ctrl, 1'h1, 32'h80 << sh);
    end
    do xfer(nsmb_pkg::off_ctrl, 1'h0, 32'h0); while (rd[7 + sh] === 1'h1);
    chk(r.err, rd[sh]);
    chk(r.elen, i_nsmb_net_model.rx_q[b]);
    chk(r.dest, i_nsmb_net_model.rx_q[8'(b + 1)]);
    for (int i = 0; i < r.elen; i++)
      chk(pb(i), i_nsmb_net_model.rx_q[8'(b + 2 + i)]);
    chk(r.elen + 2, 8'(i_nsmb_net_model.rx_n - b));
    chk(r.xp, i_nsmb_net_model.xp_q);
    xfer(nsmb_pkg::off_status, 1'h0, 32'h0);
    chk(r.dest == 0 ? 0 : (r.dest == 31 ? 2 : 1), rd[3:2]);
  endtask : send
  task automatic test_done;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  // cut a hang short
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      test_done();
    end
  end
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
    run_mode <= 1'h1;
    for (int i = 0; i < 5; i++) begin
      send(rows[i]);
      $display("row %0d done", i);
    end
    xfer(nsmb_pkg::off_param, 1'h1, 32'h14f);
    xfer(nsmb_pkg::off_active, 1'h0, 32'h0);
    chk(32'h42, rd);
    run_mode <= 1'h0;
    xfer(nsmb_pkg::off_active, 1'h0, 32'h0);
    run_mode <= 1'h1;
    xfer(nsmb_pkg::off_active, 1'h0, 32'h0);
    chk(32'h14f, rd);
    chk(8'h44, loc_id);
    sh = 8;
    send(rows[0]);
    $display("word mode done");
    xfer(nsmb_pkg::off_param, 1'h1, 32'h7fc);
    pol <= 1'h1;
    @(posedge hclk);
    pol <= 1'h0;
    xfer(nsmb_pkg::off_active, 1'h1, 32'h0);
    xfer(8'h20, 1'h1, 32'hffff);
    xfer(8'h20, 1'h0, 32'h0);
    chk(32'h0, rd);
    xfer(nsmb_pkg::off_active, 1'h0, 32'h0);
    chk(32'h7c, rd);
    chk(8'h4d, loc_id);
    hresetn <= 1'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    xfer(nsmb_pkg::off_active, 1'h0, 32'h0);
    chk(32'h42, rd);
    // a power-on load while the clock enable is low must not reach the active set
    xfer(nsmb_pkg::off_param, 1'h1, 32'h14f);
    ce <= 1'h0;
    pol <= 1'h1;
    @(posedge hclk);
    ce <= 1'h1;
    pol <= 1'h0;
    xfer(nsmb_pkg::off_active, 1'h0, 32'h0);
    chk(32'h42, rd);
    $display("parameter and reset tests done");
    test_done();
  end
endmodule : test_nsmb_top
`default_nettype wire
